/* File: core/psb_status_bank.sv */
/*
 Status flag bank: summary byte/word, input and temperature status bytes,
 read by command code; clear-faults command resets flags whose cause is gone.
 Assumes the bus engine presents command strobes synchronous to clk and that
 comparators outside present condition levels and limit values.
 The temperature is a signed level; the limit is unsigned and all ones turns
 the fault comparison off. Manufacturer and other causes set their flags but
 raise no alert. A read answer stands for one cycle, one clock after the
 command; the read data holds until the next read.
*/
`timescale 1ns/100ps
module psb_status_bank (
   // Clock, reset and command strobe
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        cmd_valid,
   input  wire logic [7:0]  cmd_code,
   input  wire logic        cmd_read,

   // Read answer
   output logic             rd_valid,
   output logic [15:0]      rd_data,
   output logic             rd_hit,

   // Measurement and limit
   input  wire logic [11:0] temp_meas,
   input  wire logic [11:0] ot_fault_limit,

   // Condition levels from the comparators
   input  wire logic        ot_warn_cond,
   input  wire logic        vin_ov_warn_cond,
   input  wire logic        vin_uv_warn_cond,
   input  wire logic        iin_oc_warn_cond,
   input  wire logic        pin_op_warn_cond,
   input  wire logic        comm_fault_cond,
   input  wire logic        mfr_fault_cond,
   input  wire logic        other_fault_cond,

   // Alert request
   output logic             alert_req
);
   // Answer registers, alert and startup bits
   typedef struct packed {
      logic        rd_valid;
      logic        rd_hit;
      logic [15:0] rd_data;
      logic        alert;
      logic        boot_input;
      logic        boot_uv;
   } psb_bank_st_t;

   psb_bank_st_t s_q;
   psb_bank_st_t s_d;

   logic        clear_cmd;
   logic        read_cmd;
   logic        ot_fault_cond;
   logic        any_cond;
   // Sticky flag outputs
   logic        ov_w;
   logic        uv_w;
   logic        oc_w;
   logic        op_w;
   logic        otf;
   logic        otw;
   logic        comm_f;
   logic        mfr_f;
   logic        other_f;
   logic [12:0] temp_ext;
   logic [12:0] limit_ext;
   logic [7:0]  in_byte;
   logic [7:0]  tmp_byte;
   logic [15:0] sum_word;
   logic [7:0]  sum_byte;

   assign clear_cmd = cmd_valid && !cmd_read && (cmd_code == psb_pkg::CMD_CLEAR_FAULTS);
   assign read_cmd  = cmd_valid && cmd_read;

   // Limit stays unsigned, else large limits would read as negative
   assign temp_ext      = {temp_meas[11], temp_meas};
   assign limit_ext     = {1'b0, ot_fault_limit};
   assign ot_fault_cond = (ot_fault_limit != psb_pkg::OT_LIMIT_DISABLED) &&
                          ($signed(temp_ext) > $signed(limit_ext));

   // Input status flags, each its own sticky latch
   psb_sticky #(
      .RST_VAL (psb_pkg::RST_IN[3])
   ) u_ov (
      .clk    (clk),
      .rstn   (rstn),
      .set_i  (vin_ov_warn_cond),
      .clr_i  (clear_cmd),
      .flag_o (ov_w)
   );

   psb_sticky #(
      .RST_VAL (psb_pkg::RST_IN[2])
   ) u_uv (
      .clk    (clk),
      .rstn   (rstn),
      .set_i  (vin_uv_warn_cond),
      .clr_i  (clear_cmd),
      .flag_o (uv_w)
   );

   psb_sticky #(
      .RST_VAL (psb_pkg::RST_IN[1])
   ) u_oc (
      .clk    (clk),
      .rstn   (rstn),
      .set_i  (iin_oc_warn_cond),
      .clr_i  (clear_cmd),
      .flag_o (oc_w)
   );

   psb_sticky #(
      .RST_VAL (psb_pkg::RST_IN[0])
   ) u_op (
      .clk    (clk),
      .rstn   (rstn),
      .set_i  (pin_op_warn_cond),
      .clr_i  (clear_cmd),
      .flag_o (op_w)
   );

   // Temperature status flags
   psb_sticky #(
      .RST_VAL (psb_pkg::RST_TMP[1])
   ) u_otf (
      .clk    (clk),
      .rstn   (rstn),
      .set_i  (ot_fault_cond),
      .clr_i  (clear_cmd),
      .flag_o (otf)
   );

   psb_sticky #(
      .RST_VAL (psb_pkg::RST_TMP[0])
   ) u_otw (
      .clk    (clk),
      .rstn   (rstn),
      .set_i  (ot_warn_cond),
      .clr_i  (clear_cmd),
      .flag_o (otw)
   );

   // Communication, manufacturer and other flags
   psb_sticky #(
      .RST_VAL (psb_pkg::RST_COMM)
   ) u_cml (
      .clk    (clk),
      .rstn   (rstn),
      .set_i  (comm_fault_cond),
      .clr_i  (clear_cmd),
      .flag_o (comm_f)
   );

   psb_sticky #(
      .RST_VAL (psb_pkg::RST_MFR)
   ) u_mfr (
      .clk    (clk),
      .rstn   (rstn),
      .set_i  (mfr_fault_cond),
      .clr_i  (clear_cmd),
      .flag_o (mfr_f)
   );

   psb_sticky #(
      .RST_VAL (psb_pkg::RST_OTHER)
   ) u_oth (
      .clk    (clk),
      .rstn   (rstn),
      .set_i  (other_fault_cond),
      .clr_i  (clear_cmd),
      .flag_o (other_f)
   );

   // Detailed input status byte
   always_comb begin
      in_byte = 8'h00;
      in_byte[psb_pkg::IN_OV_WARN] = ov_w;
      in_byte[psb_pkg::IN_UV_WARN] = uv_w;
      in_byte[psb_pkg::IN_OC_WARN] = oc_w;
      in_byte[psb_pkg::IN_OP_WARN] = op_w;
   end

   // Detailed temperature status byte
   always_comb begin
      tmp_byte = 8'h00;
      tmp_byte[psb_pkg::TMP_OT_FAULT] = otf;
      tmp_byte[psb_pkg::TMP_OT_WARN]  = otw;
   end

   // Summary word and byte
   always_comb begin
      sum_word = 16'h0000;
      sum_word[psb_pkg::SUM_INPUT] = (|in_byte) | s_q.boot_input;
      sum_word[psb_pkg::SUM_MFR]   = mfr_f;
      sum_word[psb_pkg::SUM_UV]    = uv_w | s_q.boot_uv;
      sum_word[psb_pkg::SUM_TEMP]  = |tmp_byte;
      sum_word[psb_pkg::SUM_COMM]  = comm_f;
      sum_word[psb_pkg::SUM_OTHER] = other_f | mfr_f;
      sum_byte = sum_word[7:0];
   end

   // Manufacturer and other causes raise no alert
   assign any_cond = ot_fault_cond |
                     ot_warn_cond |
                     vin_ov_warn_cond |
                     vin_uv_warn_cond |
                     iin_oc_warn_cond |
                     pin_op_warn_cond |
                     comm_fault_cond;

   always_comb begin
      s_d = s_q;
      s_d.rd_valid = 1'b0;
      s_d.rd_hit   = 1'b0;

      // Startup-set summary bits drop with the first clear-faults
      if (clear_cmd) begin
         s_d.boot_input = 1'b0;
         s_d.boot_uv    = 1'b0;
      end

      // Alert follows new events; clear-faults releases it only when no cause is live
      if (any_cond)
         s_d.alert = 1'b1;
      else if (clear_cmd)
         s_d.alert = 1'b0;

      // One-cycle answer; unknown codes give zero and no hit
      if (read_cmd) begin
         s_d.rd_valid = 1'b1;
         s_d.rd_hit   = 1'b1;
         case (cmd_code)
            psb_pkg::CMD_SUM_BYTE: begin
               s_d.rd_data = {8'h00, sum_byte};
            end
            psb_pkg::CMD_SUM_WORD: begin
               s_d.rd_data = sum_word;
            end
            psb_pkg::CMD_INPUT_BYTE: begin
               s_d.rd_data = {8'h00, in_byte};
            end
            psb_pkg::CMD_TEMP_BYTE: begin
               s_d.rd_data = {8'h00, tmp_byte};
            end
            default: begin
               s_d.rd_data = 16'h0000;
               s_d.rd_hit  = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '{
            rd_valid:   1'b0,
            rd_hit:     1'b0,
            rd_data:    16'h0000,
            alert:      1'b0,
            boot_input: psb_pkg::RST_INPUT,
            boot_uv:    psb_pkg::RST_UV
         };
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the registers
   assign rd_valid  = s_q.rd_valid;
   assign rd_hit    = s_q.rd_hit;
   assign rd_data   = s_q.rd_data;
   assign alert_req = s_q.alert;
endmodule

/* File: core/psb_pkg.sv */
/*
 Package of the status flag bank: command codes, bit positions, reset values.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package psb_pkg;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_SUM_BYTE     = 8'h78;
   localparam logic [7:0] CMD_SUM_WORD     = 8'h79;
   localparam logic [7:0] CMD_INPUT_BYTE   = 8'h7c;
   localparam logic [7:0] CMD_TEMP_BYTE    = 8'h7d;
   localparam logic [7:0] CMD_OT_FAULT_LIM = 8'h4f;
   // Summary bit positions
   localparam int SUM_INPUT = 13;
   localparam int SUM_MFR   = 12;
   localparam int SUM_UV    = 3;
   localparam int SUM_TEMP  = 2;
   localparam int SUM_COMM  = 1;
   localparam int SUM_OTHER = 0;
   // Input status byte bit positions
   localparam int IN_OV_WARN = 6;
   localparam int IN_UV_WARN = 5;
   localparam int IN_OC_WARN = 1;
   localparam int IN_OP_WARN = 0;
   // Temperature status byte bit positions
   localparam int TMP_OT_FAULT = 7;
   localparam int TMP_OT_WARN  = 6;
   // Power-on values of the startup bits and sticky latches
   localparam logic       RST_INPUT = 1'b1;
   localparam logic       RST_UV    = 1'b1;
   localparam logic       RST_MFR   = 1'b1;
   localparam logic       RST_OTHER = 1'b1;
   localparam logic [3:0] RST_IN    = 4'h0;
   localparam logic [1:0] RST_TMP   = 2'h0;
   localparam logic       RST_COMM  = 1'b0;
   localparam logic [11:0] OT_LIMIT_DISABLED = 12'hfff;
   localparam logic [11:0] OT_LIMIT_DEFAULT  = 12'h960;
endpackage

/* File: core/psb_sticky.sv */
/*
 One sticky status flag: set by an event, cleared by clear-faults only once
 the cause is gone. Assumes synchronous set/clear inputs.
*/
`timescale 1ns/100ps
module psb_sticky #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      flag_o
);
   typedef struct packed {
      logic flag;
   } psb_sticky_st_t;

   psb_sticky_st_t s_q;
   psb_sticky_st_t s_d;

   always_comb begin
      s_d = s_q;
      // Set wins; a live cause blocks the clear
      if (set_i)
         s_d.flag = 1'b1;
      else if (clr_i)
         s_d.flag = 1'b0;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         s_q <= '{flag: RST_VAL};
      else
         s_q <= s_d;
   end

   assign flag_o = s_q.flag;
endmodule

/* File: sim/psb_status_bank_sva.sv */
/* Status bank checker. Assumes a bind to psb_status_bank. */
`timescale 1ns/100ps
module psb_status_bank_sva (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        cmd_valid,
   input wire logic [7:0]  cmd_code,
   input wire logic        cmd_read,
   input wire logic        rd_valid,
   input wire logic [15:0] rd_data,
   input wire logic        rd_hit,
   input wire logic        vin_ov_warn_cond,
   input wire logic        alert_req
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   wire rd = cmd_valid && cmd_read;
   chk_read_hit: assert property (rd |=> rd_valid &&
      rd_hit == ($past(cmd_code) inside {8'h78, 8'h79, 8'h7c, 8'h7d})) else $error("bad hit");
   chk_no_stray: assert property (!rd |=> !rd_valid && !rd_hit) else $error("stray answer");
   chk_word_pad: assert property (rd && cmd_code == 8'h79 |=> ~|(rd_data & 16'hcf00)) else $error("bad word");
   chk_byte_pad: assert property (rd && cmd_code == 8'h78 |=> ~|(rd_data & 16'hfff0)) else $error("bad byte");
   chk_in_pad: assert property (rd && cmd_code == 8'h7c |=> ~|(rd_data & 16'hff9c)) else $error("bad input");
   chk_temp_pad: assert property (rd && cmd_code == 8'h7d |=> ~|(rd_data & 16'hff3f)) else $error("bad temp");
   chk_ov_alert: assert property (vin_ov_warn_cond |=> alert_req) else $error("no alert");
   chk_alert_held: assert property (alert_req && !(cmd_valid && !cmd_read && cmd_code == 8'h03) |=> alert_req)
      else $error("alert dropped");
endmodule
bind psb_status_bank psb_status_bank_sva i_psb_status_bank_sva (.*);

/* File: sim/psb_host.sv */
/* Host model of the status bank. Assumes a one-cycle answer. */
`timescale 1ns/100ps
module psb_host (
   input  wire logic        clk,
   output logic             cmd_valid,
   output logic [7:0]       cmd_code,
   output logic             cmd_read,
   input  wire logic        rd_valid,
   input  wire logic        rd_hit,
   input  wire logic [15:0] rd_data
);
   initial {cmd_valid, cmd_read, cmd_code} = 10'h000;
   // Read byte, read word or send byte; released code lines inverted
   task automatic xfer(input logic [7:0] code, input logic r, output logic [15:0] d, output logic [1:0] vh);
      @(negedge clk);
      {cmd_valid, cmd_read, cmd_code} = {1'b1, r, code};
      @(negedge clk);
      {vh, d} = {rd_valid, rd_hit, rd_data};
      {cmd_valid, cmd_code} = {1'b0, ~code};
   endtask
endmodule

/* File: sim/psb_status_bank_tb.sv */
/* Status bank bench. Assumes the host model and checker. */
`timescale 1ns/100ps
module psb_status_bank_tb;
   logic        clk = 1'b0;
   logic        rstn, cmd_valid, cmd_read, rd_valid, rd_hit, alert_req;
   logic [7:0]  cmd_code;
   logic [8:0]  c;
   logic [11:0] temp_meas, ot_fault_limit, hot;
   logic [15:0] rd_data;
   int          num_errors = 0;
   int          check_count = 0;
   // Per condition: word, detail command, detail byte
   localparam logic [31:0] T [9] = '{32'h0004_7d40, 32'h2000_7c40, 32'h2008_7c20, 32'h2000_7c02, 32'h2000_7c01,
      32'h0002_7802, 32'h1001_7801, 32'h0001_7801, 32'h0004_7d80};
   // Per limit case: limit, hot temperature, temperature byte
   localparam logic [31:0] F [4] = '{32'h9601_0000, 32'hfff7_ff00, 32'h0fff_0000, 32'h0ff7_ff80};
   assign temp_meas = c[8] ? hot : 12'h000;
   psb_status_bank i_psb_status_bank (.*, .ot_warn_cond(c[0]), .vin_ov_warn_cond(c[1]), .vin_uv_warn_cond(c[2]),
      .iin_oc_warn_cond(c[3]), .pin_op_warn_cond(c[4]), .comm_fault_cond(c[5]), .mfr_fault_cond(c[6]),
      .other_fault_cond(c[7]));
   psb_host i_psb_host (.*);
   initial forever #2.5 clk = ~clk;
   task automatic acc(input logic [7:0] code, input logic [15:0] exp, input logic r = 1'b1);
      logic [17:0] g, e;
      e = {r, r && (code inside {8'h78, 8'h79, 8'h7c, 8'h7d}), r ? exp : 16'h0000};
      i_psb_host.xfer(code, r, g[15:0], g[17:16]);
      if (!r) g[15:0] = 16'h0000;
      check_count++;
      if (g !== e) num_errors++;
      if (g !== e) $display("CHECK FAILED cmd %h expected %h seen %h", code, e, g);
   endtask
   task automatic chk_alert(input logic exp);
      check_count++;
      if (alert_req !== exp) begin
         num_errors++;
         $display("CHECK FAILED alert_req expected %b seen %b", exp, alert_req);
      end
   endtask
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #20000 num_errors++;
      give_verdict();
   end
   initial begin
      rstn = 1'b0;
      c = 9'h000;
      {ot_fault_limit, hot} = 24'h0ff_100;
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      acc(8'h79, 16'h3009);
      acc(8'h78, 16'h0009);
      acc(8'h19, 16'h0000);
      chk_alert(1'b0);
      $display("Test power-on values done");
      c = 9'h004;
      acc(8'h03, 16'h0000, 1'b0);
      acc(8'h7c, 16'h0020);
      chk_alert(1'b1);
      c = 9'h000;
      acc(8'h03, 16'h0000, 1'b0);
      chk_alert(1'b0);
      $display("Test clear with cause held done");
      for (int i = 0; i < 9; i++) begin
         @(negedge clk) c = 9'h001 << i;
         @(negedge clk) c = 9'h000;
         acc(8'h79, T[i][31:16]);
         acc(T[i][15:8], {8'h00, T[i][7:0]});
         chk_alert(i != 6 && i != 7);
         acc(8'h03, 16'h0000, 1'b0);
         chk_alert(1'b0);
      end
      $display("Test each flag done");
      for (int k = 0; k < 4; k++) begin
         @(negedge clk) begin
            {ot_fault_limit, hot} = F[k][31:8];
            c = 9'h100;
         end
         @(negedge clk) c = 9'h000;
         acc(8'h7d, {8'h00, F[k][7:0]});
         chk_alert(F[k][7:0] != 8'h00);
         acc(8'h03, 16'h0000, 1'b0);
         chk_alert(1'b0);
      end
      $display("Test fault limit done");
      @(negedge clk) rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      acc(8'h79, 16'h3009);
      acc(8'h7d, 16'h0000);
      chk_alert(1'b0);
      $display("Test second reset done");
      give_verdict();
   end
endmodule
